// ---- logic/csc_regs.svh ----
// Register map, field positions, reset values and timing counts of the clock source controller.
// Assumes a byte-addressed Avalon-MM slave in which each 8-bit register sits in a 32-bit word.
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// Register indices; byte address is four times the index
`define CSC_IDX_MAIN_SELECT    8'h00
`define CSC_IDX_MAIN_PRESCALE  8'h01
`define CSC_IDX_MAIN_LOCK      8'h02
`define CSC_IDX_MAIN_STATUS    8'h03
`define CSC_IDX_FAST_CONTROL   8'h10
`define CSC_IDX_FAST_TRIM      8'h11
`define CSC_IDX_FAST_TEMP_TRIM 8'h12
`define CSC_IDX_SLOW_CONTROL   8'h18
`define CSC_IDX_XTAL_CONTROL   8'h1c
`define CSC_IDX_PROTECT_KEY    8'h20

// Key that opens the timed-write window; value is arbitrary
`define CSC_IO_REGISTER_KEY    8'h5a
// Window length in core clocks after the key is written
`define CSC_UNLOCK_CYCLES      3'd4

// Field positions
`define CSC_SEL_CLKOUT_BIT     7
`define CSC_PRE_ENABLE_BIT     0
`define CSC_LOCK_ENABLE_BIT    0
`define CSC_STS_EXT_BIT        7
`define CSC_STS_XTAL_BIT       6
`define CSC_STS_SLOW_BIT       5
`define CSC_STS_FAST_BIT       4
`define CSC_STS_SWITCH_BIT     0
`define CSC_RUN_STANDBY_BIT    1
`define CSC_XTAL_ENABLE_BIT    0
`define CSC_XTAL_SEL_BIT       2
`define CSC_XTAL_SUT_LSB       4
`define CSC_TEMP_LOCK_BIT      7

// Reset values
`define CSC_RST_MAIN_SELECT    8'h00
`define CSC_RST_MAIN_PRESCALE  8'h11
`define CSC_RST_ZERO           8'h00

// Oscillator start-up counts, in oscillator cycles after analog start-up
`define CSC_RC_GATE_CYCLES     16'd4
`define CSC_EXT_START_CYCLES   16'd2
`define CSC_XTAL_SUT_0         16'd256
`define CSC_XTAL_SUT_1         16'd1024
`define CSC_XTAL_SUT_2         16'd4096
`define CSC_XTAL_SUT_3         16'd16384
// Terminal count of the 1 kHz divider: 32 slow oscillator cycles per tick
`define CSC_KHZ_DIV            5'd31

`endif

// ---- logic/csc_pkg.sv ----
// Types shared by the clock source controller modules.
// Assumes csc_regs.svh supplies the numeric constants.
`default_nettype none
package csc_pkg;
  typedef enum logic [1:0] {
    CSC_SRC_FAST,
    CSC_SRC_SLOW,
    CSC_SRC_XTAL,
    CSC_SRC_EXT
  } csc_source_t;

  typedef enum logic {
    CSC_SW_IDLE,
    CSC_SW_WAIT
  } csc_switch_t;

  // Prescale divisor code to division ratio; reserved codes fall back to 2
  function automatic logic [6:0] csc_prescale_divisor_ratio(input logic [3:0] code);
    case (code)
      4'h0:    csc_prescale_divisor_ratio = 7'd2;
      4'h1:    csc_prescale_divisor_ratio = 7'd4;
      4'h2:    csc_prescale_divisor_ratio = 7'd8;
      4'h3:    csc_prescale_divisor_ratio = 7'd16;
      4'h4:    csc_prescale_divisor_ratio = 7'd32;
      4'h5:    csc_prescale_divisor_ratio = 7'd64;
      4'h8:    csc_prescale_divisor_ratio = 7'd6;
      4'h9:    csc_prescale_divisor_ratio = 7'd10;
      4'ha:    csc_prescale_divisor_ratio = 7'd12;
      4'hb:    csc_prescale_divisor_ratio = 7'd24;
      4'hc:    csc_prescale_divisor_ratio = 7'd48;
      default: csc_prescale_divisor_ratio = 7'd2;
    endcase
  endfunction

  typedef struct packed {
    logic [15:0] cnt;
    logic        ready;
  } csc_start_state_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } csc_div_state_t;
endpackage
`default_nettype wire

// ---- logic/csc_osc_start.sv ----
// Start-up gate of one clock source: counts oscillator cycles after analog start-up.
// Assumes i_osc_tick is a one-cycle pulse per oscillator cycle, synchronous to i_core_clk.
`default_nettype none
module csc_osc_start
  import csc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_run,
  input  wire logic        i_analog_ready,
  input  wire logic        i_osc_tick,
  input  wire logic [15:0] i_need,
  output logic             o_ready
);
  csc_start_state_t st;
  csc_start_state_t next_st;

  // Gate opens once the required oscillator cycles have been seen
  always_comb begin
    next_st = st;
    if (!i_run) begin
      next_st.cnt   = 16'h0000;
      next_st.ready = 1'b0;
    end else if (!st.ready && i_analog_ready) begin
      if (st.cnt >= i_need) begin
        next_st.ready = 1'b1;
      end else if (i_osc_tick) begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_ready = st.ready;
endmodule
`default_nettype wire

// ---- logic/csc_prescaler.sv ----
// Peripheral clock prescaler: one tick every ratio main clocks, or every clock when bypassed.
// Assumes i_core_clk stands for the selected main clock.
`default_nettype none
module csc_prescaler
  import csc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_enable,
  input  wire logic [6:0] i_ratio,
  output logic            o_tick
);
  csc_div_state_t st;
  csc_div_state_t next_st;

  // Ratio change takes effect at once; a count already past the new ratio wraps on the next clock
  always_comb begin
    next_st = st;
    if (!i_enable) begin
      next_st.cnt  = 7'd0;
      next_st.tick = 1'b1;
    end else if (st.cnt >= i_ratio - 7'd1) begin
      next_st.cnt  = 7'd0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt  = st.cnt + 7'd1;
      next_st.tick = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;
endmodule
`default_nettype wire

// ---- logic/csc_top.sv ----
// Clock source controller: main source selection, prescaler, start-up gating, trim and
// timed-write protection, reached over an Avalon-MM slave with waitrequest.
// Assumes oscillators report analog start-up and one tick per cycle on synchronous inputs.
//
// The implementer's own choice: the Avalon-MM slave port.
`default_nettype none
`include "csc_regs.svh"

module csc_top
  import csc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_freq_select_fuse_field,
  input  wire logic [5:0]  i_fuse_center_trim,
  input  wire logic [3:0]  i_fuse_temp_slope_trim,
  input  wire logic        i_trim_lock_fuse,
  input  wire logic [3:0]  i_periph_req,
  input  wire logic        i_khz_consumer_req,
  input  wire logic [2:0]  i_osc_analog_ready,
  input  wire logic [3:0]  i_osc_tick,
  output logic [3:0]       o_osc_enable,
  output logic [3:0]       o_osc_gate_open,
  output logic [1:0]       o_main_source,
  output logic             o_per_clk_tick,
  output logic             o_fast_rc_osc_20mhz,
  output logic [5:0]       o_center_trim,
  output logic [3:0]       o_temp_slope_trim,
  output logic             o_khz_tick,
  output logic             o_xtal_pins_dedicated,
  output logic             o_xtal_ext_clock_mode,
  output logic             o_ext_clock_pin_input,
  output logic             o_clock_out_enable
);

  // Register state of the block, apart from the start-up gates and the prescaler
  typedef struct packed {
    logic        waitreq;
    logic [7:0]  rdata;
    logic [1:0]  sel;
    logic        clkout;
    logic [3:0]  prescale_divisor;
    logic        prescale_enable;
    logic        lock_en;
    logic        fast_rs;
    logic        slow_rs;
    logic [5:0]  center_trim;
    logic [3:0]  temp_trim;
    logic        xtal_en;
    logic        xtal_rs;
    logic        xtal_sel;
    logic [1:0]  xtal_sut;
    logic [2:0]  unlock;
    csc_switch_t sw;
    logic [1:0]  target;
    logic        ext_started;
    logic [3:0]  stable;
    logic [3:0]  osc_en;
    logic        f20;
    logic [4:0]  khz_cnt;
    logic        khz_tick;
    logic        per_tick;
  } csc_top_state_t;

  csc_top_state_t st;
  csc_top_state_t next_st;

  logic [3:0]  req;
  logic [3:0]  run;
  logic [3:0]  ready;
  logic [3:0]  analog;
  logic [15:0] need [4];
  logic [15:0] xtal_need;
  logic        per_tick;
  logic        bus_req;
  logic        accept;
  logic [7:0]  index;
  logic        word_ok;
  logic [7:0]  wbyte;
  logic        wr_ok;
  logic        unlocked;
  logic        cal_locked;
  logic        main_locked;
  logic [7:0]  rd_value;

  // Register index from a byte address; the low two bits are dropped, so reads decode at any offset and only writes need word alignment
  function automatic logic [7:0] reg_index(input logic [7:0] addr);
    reg_index = {2'b00, addr[7:2]};
  endfunction

  // Register read view; unmapped and reserved bits read zero
  function automatic logic [7:0] reg_read(input csc_top_state_t s, input logic [7:0] idx,
                                          input logic lock_fuse);
    case (idx)
      `CSC_IDX_MAIN_SELECT:    reg_read = {s.clkout, 5'b00000, s.sel};
      `CSC_IDX_MAIN_PRESCALE:  reg_read = {3'b000, s.prescale_divisor, s.prescale_enable};
      `CSC_IDX_MAIN_LOCK:      reg_read = {7'b0000000, s.lock_en};
      `CSC_IDX_MAIN_STATUS:    reg_read = {s.stable[3], s.stable[2], s.stable[1], s.stable[0],
                                           3'b000, s.sw == CSC_SW_WAIT};
      `CSC_IDX_FAST_CONTROL:   reg_read = {6'b000000, s.fast_rs, 1'b0};
      `CSC_IDX_FAST_TRIM:      reg_read = {2'b00, s.center_trim};
      `CSC_IDX_FAST_TEMP_TRIM: reg_read = {lock_fuse, 3'b000, s.temp_trim};
      `CSC_IDX_SLOW_CONTROL:   reg_read = {6'b000000, s.slow_rs, 1'b0};
      `CSC_IDX_XTAL_CONTROL:   reg_read = {2'b00, s.xtal_sut, 1'b0, s.xtal_sel, s.xtal_rs,
                                           s.xtal_en};
      `CSC_IDX_PROTECT_KEY:    reg_read = {7'b0000000, s.unlock != 3'd0};
      default:                 reg_read = 8'h00;
    endcase
  endfunction

  // Bus decode; a request is taken at the edge where waitrequest is low
  always_comb begin
    bus_req  = i_avs_read || i_avs_write;
    accept   = bus_req && !st.waitreq;
    index    = reg_index(i_avs_address);
    word_ok  = i_avs_address[1:0] == 2'b00;
    wbyte    = i_avs_writedata[7:0];
    wr_ok    = accept && i_avs_write && word_ok && i_avs_byteenable[0];
    unlocked = st.unlock != 3'd0;
    cal_locked  = i_trim_lock_fuse ||
                  (st.lock_en && st.sel == 2'(CSC_SRC_FAST));
    main_locked = st.lock_en;
    rd_value = reg_read(st, index, i_trim_lock_fuse);
  end

  // Source requests and run enables; peripherals need no software enable, except that the crystal also needs xtal_en
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      req[s] = i_periph_req[s] || (st.sel == 2'(s)) ||
               (st.sw == CSC_SW_WAIT && st.target == 2'(s));
    end
    req[CSC_SRC_SLOW] = req[CSC_SRC_SLOW] || i_khz_consumer_req;
    run[CSC_SRC_FAST] = req[CSC_SRC_FAST] || st.fast_rs;
    run[CSC_SRC_SLOW] = req[CSC_SRC_SLOW] || st.slow_rs;
    run[CSC_SRC_XTAL] = (req[CSC_SRC_XTAL] || st.xtal_rs) && st.xtal_en;
    run[CSC_SRC_EXT]  = req[CSC_SRC_EXT];
  end

  // Start-up delay per source
  always_comb begin
    case (st.xtal_sut)
      2'd0:    xtal_need = `CSC_XTAL_SUT_0;
      2'd1:    xtal_need = `CSC_XTAL_SUT_1;
      2'd2:    xtal_need = `CSC_XTAL_SUT_2;
      default: xtal_need = `CSC_XTAL_SUT_3;
    endcase
    need[CSC_SRC_FAST] = `CSC_RC_GATE_CYCLES;
    need[CSC_SRC_SLOW] = `CSC_RC_GATE_CYCLES;
    need[CSC_SRC_XTAL] = st.xtal_sel ? `CSC_EXT_START_CYCLES : xtal_need;
    need[CSC_SRC_EXT]  = st.ext_started ? 16'd0 : `CSC_EXT_START_CYCLES;
    analog[CSC_SRC_FAST] = i_osc_analog_ready[0];
    analog[CSC_SRC_SLOW] = i_osc_analog_ready[1];
    // An external clock has no analog start-up of its own
    analog[CSC_SRC_XTAL] = st.xtal_sel || i_osc_analog_ready[2];
    analog[CSC_SRC_EXT]  = 1'b1;
  end

  // One start-up gate per source
  for (genvar g = 0; g < 4; g++) begin : g_start
    csc_osc_start u_start (
      .i_core_clk     (i_core_clk),
      .i_rst          (i_rst),
      .i_run          (run[g]),
      .i_analog_ready (analog[g]),
      .i_osc_tick     (i_osc_tick[g]),
      .i_need         (need[g]),
      .o_ready        (ready[g])
    );
  end

  // Peripheral clock divider
  csc_prescaler u_prescaler (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_enable   (st.prescale_enable),
    .i_ratio    (csc_prescale_divisor_ratio(st.prescale_divisor)),
    .o_tick     (per_tick)
  );

  // Next-state logic: bus slave, protected writes, switching and status
  always_comb begin
    next_st          = st;
    next_st.per_tick = per_tick;
    next_st.osc_en   = run;
    // Stable only while requested and after the full gate delay
    next_st.stable   = ready & req;

    // Waitrequest drops for one cycle after each new request
    next_st.waitreq = !(bus_req && st.waitreq);
    if (bus_req && st.waitreq) begin
      next_st.rdata = rd_value;
    end

    // Window closes by itself; limited to a few cycles so stray writes stay harmless
    if (unlocked) begin
      next_st.unlock = st.unlock - 3'd1;
    end

    if (wr_ok && index == `CSC_IDX_PROTECT_KEY) begin
      if (wbyte == `CSC_IO_REGISTER_KEY) begin
        next_st.unlock = `CSC_UNLOCK_CYCLES;
      end
    end else if (wr_ok && unlocked) begin
      // Any protected write uses up the window, even one that a lock then drops
      next_st.unlock = 3'd0;
      case (index)
        `CSC_IDX_MAIN_SELECT: begin
          if (!main_locked) begin
            next_st.clkout = wbyte[`CSC_SEL_CLKOUT_BIT];
            // No new switch while one is pending
            if (st.sw == CSC_SW_IDLE && wbyte[1:0] != st.sel) begin
              next_st.sw     = CSC_SW_WAIT;
              next_st.target = wbyte[1:0];
            end
          end
        end
        `CSC_IDX_MAIN_PRESCALE: begin
          if (!main_locked) begin
            next_st.prescale_divisor = wbyte[4:1];
            next_st.prescale_enable  = wbyte[`CSC_PRE_ENABLE_BIT];
          end
        end
        `CSC_IDX_MAIN_LOCK: begin
          // Once set, stays until reset
          if (!st.lock_en) begin
            next_st.lock_en = wbyte[`CSC_LOCK_ENABLE_BIT];
          end
        end
        `CSC_IDX_FAST_CONTROL: next_st.fast_rs = wbyte[`CSC_RUN_STANDBY_BIT];
        `CSC_IDX_FAST_TRIM: begin
          if (!cal_locked) begin
            next_st.center_trim = wbyte[5:0];
          end
        end
        `CSC_IDX_FAST_TEMP_TRIM: begin
          if (!cal_locked) begin
            next_st.temp_trim = wbyte[3:0];
          end
        end
        `CSC_IDX_SLOW_CONTROL: next_st.slow_rs = wbyte[`CSC_RUN_STANDBY_BIT];
        `CSC_IDX_XTAL_CONTROL: begin
          next_st.xtal_en  = wbyte[`CSC_XTAL_ENABLE_BIT];
          next_st.xtal_rs  = wbyte[`CSC_RUN_STANDBY_BIT];
          next_st.xtal_sel = wbyte[`CSC_XTAL_SEL_BIT];
          next_st.xtal_sut = wbyte[`CSC_XTAL_SUT_LSB +: 2];
        end
        default: ;
      endcase
    end

    // Switch completes once the new source has passed its start-up
    case (st.sw)
      CSC_SW_IDLE: ;
      CSC_SW_WAIT: begin
        if (ready[st.target]) begin
          next_st.sel = st.target;
          next_st.sw  = CSC_SW_IDLE;
        end
      end
      default: next_st.sw = CSC_SW_IDLE;
    endcase

    if (ready[CSC_SRC_EXT]) begin
      next_st.ext_started = 1'b1;
    end

    // 1 kHz tick from the low-power oscillator
    next_st.khz_tick = 1'b0;
    if (ready[CSC_SRC_SLOW] && i_osc_tick[CSC_SRC_SLOW]) begin
      if (st.khz_cnt == `CSC_KHZ_DIV) begin
        next_st.khz_cnt  = 5'd0;
        next_st.khz_tick = 1'b1;
      end else begin
        next_st.khz_cnt = st.khz_cnt + 5'd1;
      end
    end
  end

  // State register; synchronous reset may sample fuses
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      // Fuses are taken again on every reset, so a mid-run reset restores the trims
      st             <= '0;
      st.waitreq     <= 1'b1;
      st.sel         <= 2'(`CSC_RST_MAIN_SELECT);
      {st.prescale_divisor, st.prescale_enable} <= 5'(`CSC_RST_MAIN_PRESCALE);
      st.center_trim <= i_fuse_center_trim;
      st.temp_trim   <= i_fuse_temp_slope_trim;
      st.f20         <= i_freq_select_fuse_field;
      st.sw          <= CSC_SW_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flip-flops
  assign o_avs_readdata        = {24'h000000, st.rdata};
  assign o_avs_waitrequest     = st.waitreq;
  assign o_osc_enable          = st.osc_en;
  assign o_osc_gate_open       = st.stable;
  assign o_main_source         = st.sel;
  assign o_per_clk_tick        = st.per_tick;
  assign o_fast_rc_osc_20mhz   = st.f20;
  assign o_center_trim         = st.center_trim;
  assign o_temp_slope_trim     = st.temp_trim;
  assign o_khz_tick            = st.khz_tick;
  assign o_xtal_pins_dedicated = st.xtal_en;
  assign o_xtal_ext_clock_mode = st.xtal_sel;
  assign o_ext_clock_pin_input = st.osc_en[CSC_SRC_EXT];
  assign o_clock_out_enable    = st.clkout;
endmodule
`default_nettype wire

// ---- testbench/csc_osc_model.sv ----
// Oscillator model: analog start-up delay, then one tick every other core clock.
// Assumes it shares the controller's core clock and follows its run enables.
`default_nettype none
module csc_osc_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_osc_enable,
  output logic [2:0]      o_analog_ready,
  output logic [3:0]      o_osc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] dly [3];
  logic       ph;
  // Ready three clocks after enable; drops at once so a stop is never hidden
  always_ff @(posedge i_core_clk) begin
    ph <= i_rst ? 1'b0 : !ph;
    for (int k = 0; k < 3; k++) begin
      if (i_rst || !i_osc_enable[k]) dly[k] <= 2'd0;
      else if (dly[k] != 2'd3) dly[k] <= dly[k] + 2'd1;
    end
  end
  // Only a started oscillator ticks; the external clock runs free
  always_comb begin
    for (int k = 0; k < 3; k++) o_analog_ready[k] = (dly[k] == 2'd3);
    o_osc_tick = {ph, o_analog_ready & {3{ph}}};
  end
endmodule
`default_nettype wire

// ---- testbench/csc_properties.sv ----
// Concurrent checks of the clock source controller, seen from its top-level ports.
// Assumes one core clock and a synchronous active-high reset.
`default_nettype none
module csc_properties (
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_trim_lock_fuse,
  input wire logic [5:0] i_fuse_center_trim,
  input wire logic [3:0] i_periph_req,
  input wire logic       i_khz_consumer_req,
  input wire logic [2:0] i_osc_analog_ready,
  input wire logic [3:0] o_osc_enable,
  input wire logic [3:0] o_osc_gate_open,
  input wire logic [1:0] o_main_source,
  input wire logic [5:0] o_center_trim,
  input wire logic       o_khz_tick,
  input wire logic       o_xtal_pins_dedicated,
  input wire logic       o_ext_clock_pin_input
);
  logic [3:0] gate_q;
  // Gate state one clock back, so a switch may land on the opening edge
  always_ff @(posedge i_core_clk) gate_q <= o_osc_gate_open;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // No peripheral, 1 kHz consumer or main selection asks for the slow oscillator
  sequence slow_idle;
    !i_periph_req[1] && !i_khz_consumer_req && (o_main_source != 2'h1);
  endsequence
  a_reset_main_fast: assert property ($fell(i_rst) |-> o_main_source == 2'h0)
    else $error("main source not fast after reset");
  a_reset_trim_load: assert property ($fell(i_rst) |-> o_center_trim == i_fuse_center_trim)
    else $error("centre trim not loaded from fuse");
  a_fuse_trim_lock: assert property (i_trim_lock_fuse |=> $stable(o_center_trim))
    else $error("trim changed under lock fuse");
  a_rc_gate_wait: assert property ($rose(o_osc_gate_open[1])
      |-> $past(i_osc_analog_ready[1], 4))
    else $error("slow gate opened too early");
  a_slow_gate_drop: assert property (slow_idle ##1 slow_idle |=> !o_osc_gate_open[1])
    else $error("slow gate open while unrequested");
  a_switch_when_ready: assert property ($changed(o_main_source)
      |-> gate_q[o_main_source] || o_osc_gate_open[o_main_source])
    else $error("main source switched to unstable source");
  a_ext_pin_input: assert property (i_periph_req[3] [*2] |-> o_ext_clock_pin_input)
    else $error("external pin not made input");
  a_auto_enable: assert property (i_periph_req[1] [*2] |-> o_osc_enable[1])
    else $error("requested oscillator not enabled");
  a_xtal_needs_enable: assert property (!o_xtal_pins_dedicated [*2] |-> !o_osc_enable[2])
    else $error("crystal runs without enable");
  a_khz_tick_pulse: assert property (o_khz_tick |=> !o_khz_tick [*8])
    else $error("kilohertz tick too close");
endmodule
bind csc_top csc_properties chk_u (.i_core_clk, .i_rst, .i_trim_lock_fuse, .i_fuse_center_trim,
  .i_periph_req, .i_khz_consumer_req, .i_osc_analog_ready, .o_osc_enable, .o_osc_gate_open,
  .o_main_source, .o_center_trim, .o_khz_tick, .o_xtal_pins_dedicated, .o_ext_clock_pin_input);
`default_nettype wire

// ---- testbench/clock_source_controller_bench.sv ----
// Self-checking bench of the clock source controller through its Avalon-MM slave.
// Assumes the oscillator model answers the run enables and the checker is bound.
`default_nettype none
module clock_source_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, rd, wr, trim_lk, khz_rq, waitreq, ptick, f20, pins, xmode, extin;
  logic        ktick, ckout;
  logic [7:0]  adr, q;
  logic [31:0] wd, rdat;
  logic [3:0]  req, oen, gate, tick, ttrim;
  logic [2:0]  ardy;
  logic [1:0]  msrc;
  logic [5:0]  ctrim;
  int          fail_count, check_count, cyc;
  csc_top dut_u (.i_core_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(waitreq), .i_freq_select_fuse_field(1'b1),
    .i_fuse_center_trim(6'h2a), .i_fuse_temp_slope_trim(4'h9), .i_trim_lock_fuse(trim_lk),
    .i_periph_req(req), .i_khz_consumer_req(khz_rq), .i_osc_analog_ready(ardy),
    .i_osc_tick(tick), .o_osc_enable(oen), .o_osc_gate_open(gate), .o_main_source(msrc),
    .o_per_clk_tick(ptick), .o_fast_rc_osc_20mhz(f20), .o_center_trim(ctrim),
    .o_temp_slope_trim(ttrim), .o_khz_tick(ktick), .o_xtal_pins_dedicated(pins),
    .o_xtal_ext_clock_mode(xmode), .o_ext_clock_pin_input(extin), .o_clock_out_enable(ckout));
  csc_osc_model osc_u (.i_core_clk(clk), .i_rst(rst), .i_osc_enable(oen),
    .o_analog_ready(ardy), .o_osc_tick(tick));
  // Free-running core clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus cycle: held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= {24'h0, d};
    // Only the global hang guard ends this wait
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  // Key first, so the write lands inside the short unlock window
  task automatic wrk(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 8'h80, 8'h5a);
    bus(1'b1, a, d);
  endtask
  task automatic wait_gate(input int i);
    int n;
    n = 0;
    while (gate[i] !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, gate[i]}, 8'h01);
  endtask
  // Settle, then count peripheral or 1 kHz ticks over a whole number of periods
  task automatic cnt_tick(input logic khz, input int span, input logic [7:0] e);
    int k;
    k = 0;
    repeat (8) @(posedge clk);
    repeat (span) begin
      @(posedge clk);
      k += khz ? (ktick === 1'b1) : (ptick === 1'b1);
    end
    chk(k[7:0], e);
  endtask
  initial begin
    rst = 1'b1;
    {rd, wr, trim_lk, khz_rq, adr, wd, req} = '0;
    {fail_count, check_count, cyc} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd8(8'h00, 8'h00);
    rd8(8'h04, 8'h11);
    rd8(8'h44, 8'h2a);
    rd8(8'h48, 8'h09);
    chk({7'h0, f20}, 8'h01);
    rd8(8'h14, 8'h00);
    $display("test reset values done");
    bus(1'b1, 8'h44, 8'h15);
    rd8(8'h44, 8'h2a);
    bus(1'b1, 8'h04, 8'h00);
    rd8(8'h04, 8'h11);
    wrk(8'h04, 8'h03);
    rd8(8'h04, 8'h03);
    wrk(8'h44, 8'hff);
    rd8(8'h44, 8'h3f);
    wrk(8'h48, 8'hff);
    rd8(8'h48, 8'h0f);
    chk({4'h0, ttrim}, 8'h0f);
    wrk(8'h04, 8'h11);
    trim_lk <= 1'b1;
    wrk(8'h44, 8'h01);
    rd8(8'h44, 8'h3f);
    rd8(8'h48, 8'h8f);
    trim_lk <= 1'b0;
    $display("test protection and trim done");
    wrk(8'h04, 8'h00);
    cnt_tick(1'b0, 24, 8'd24);
    wrk(8'h04, 8'h01);
    cnt_tick(1'b0, 24, 8'd12);
    wrk(8'h04, 8'h11);
    cnt_tick(1'b0, 24, 8'd4);
    $display("test prescaler done");
    req <= 4'h2;
    khz_rq <= 1'b1;
    wait_gate(1);
    rd8(8'h0c, 8'h30);
    wrk(8'h00, 8'h81);
    repeat (4) @(posedge clk);
    chk({6'h0, msrc}, 8'h01);
    chk({7'h0, ckout}, 8'h01);
    // 128 clocks hold 64 slow ticks, so exactly two 1 kHz pulses
    cnt_tick(1'b1, 128, 8'd2);
    wrk(8'h00, 8'h00);
    wait_gate(0);
    repeat (4) @(posedge clk);
    chk({6'h0, msrc}, 8'h00);
    {req, khz_rq} <= '0;
    repeat (4) @(posedge clk);
    chk({7'h0, gate[1]}, 8'h00);
    wrk(8'h60, 8'h02);
    repeat (20) @(posedge clk);
    chk({6'h0, oen[1], gate[1]}, 8'h02);
    req <= 4'h2;
    repeat (2) @(posedge clk);
    chk({7'h0, gate[1]}, 8'h01);
    $display("test sources and switch done");
    req <= 4'h4;
    repeat (20) @(posedge clk);
    chk({7'h0, oen[2]}, 8'h00);
    wrk(8'h70, 8'h05);
    wait_gate(2);
    chk({6'h0, pins, xmode}, 8'h03);
    req <= 4'hc;
    wait_gate(3);
    chk({7'h0, extin}, 8'h01);
    req <= 4'h0;
    $display("test external sources done");
    wrk(8'h08, 8'h01);
    wrk(8'h44, 8'h05);
    rd8(8'h44, 8'h3f);
    wrk(8'h04, 8'h00);
    rd8(8'h04, 8'h11);
    $display("test main clock lock done");
    // Second reset in mid-run must drop the lock and reload the fuse trims
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd8(8'h08, 8'h00);
    rd8(8'h44, 8'h2a);
    rd8(8'h04, 8'h11);
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
